//--- hdl/mdst_top.sv
// Purpose: command driven drive motor controller with trims, timed moves and ramping
// Assumes: Avalon-MM master on sys_clk_in, byte addresses, 32-bit data
// Notes: every bus access is answered one cycle after it is seen
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module mdst_top #(
  parameter int TICK_CYCLES = mdst_pkg::SPEED_TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic left_pwm_out,
  output logic left_fwd_out,
  output logic right_pwm_out,
  output logic right_fwd_out
);

  mdst_pkg::mdst_state_t q;
  mdst_pkg::mdst_state_t d;
  logic [6:0] left_speed;
  logic [6:0] right_speed;
  logic left_fwd;
  logic right_fwd;
  logic [31:0] status_word;
  logic [31:0] setup_word;
  logic [31:0] speeds_word;
  logic [31:0] trims_word;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // trim only ever lowers: result = speed * (100 - trim) / 100
  function automatic logic [6:0] trimmed(input logic [6:0] speed, input logic [6:0] trim);
    logic [13:0] prod;
    prod = 14'(speed) * 14'(mdst_pkg::FULL_SPEED - trim);
    return 7'(prod / 14'(mdst_pkg::FULL_SPEED));
  endfunction

  function automatic logic [6:0] pct(input logic [7:0] v);
    return (v > {1'b0, mdst_pkg::FULL_SPEED}) ? mdst_pkg::FULL_SPEED : v[6:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic wr_go;
  logic [7:0] code;
  logic [7:0] qual;
  logic [1:0] kind;
  logic [15:0] amount;
  logic [6:0] base;
  logic [7:0] scale;

  always_comb
  begin
    d = q;
    wr_go = avs_write_in && !q.waitreq;
    code = avs_writedata_in[15:8];
    qual = avs_writedata_in[7:0];
    kind = avs_writedata_in[1:0];
    amount = avs_writedata_in[31:mdst_pkg::MOTION_AMOUNT_LSB];
    base = q.spd_normal;
    scale = q.move_time;

    // read words, assembled field by field
    status_word = 32'h0000_0000;
    status_word[mdst_pkg::STATUS_MOTION_LSB +: 2] = q.motion;
    status_word[mdst_pkg::STATUS_CONFIGURED_BIT] = q.configured;
    status_word[mdst_pkg::STATUS_LEFT_FWD_BIT] = left_fwd;
    status_word[mdst_pkg::STATUS_RIGHT_FWD_BIT] = right_fwd;
    status_word[mdst_pkg::STATUS_LEFT_SPEED_LSB +: 7] = left_speed;
    status_word[mdst_pkg::STATUS_RIGHT_SPEED_LSB +: 7] = right_speed;
    setup_word = 32'h0000_0000;
    setup_word[mdst_pkg::SETUP_TYPE_MSB:0] = q.mtype;
    setup_word[mdst_pkg::SETUP_ENCODER_BIT] = q.encoder;
    setup_word[mdst_pkg::SETUP_TURN_LSB +: 8] = q.turn_time;
    setup_word[mdst_pkg::SETUP_MOVE_LSB +: 8] = q.move_time;
    setup_word[mdst_pkg::SETUP_ACCEL_LSB +: 8] = q.accel_step;
    speeds_word = 32'h0000_0000;
    speeds_word[mdst_pkg::SPEEDS_NORMAL_LSB +: 7] = q.spd_normal;
    speeds_word[mdst_pkg::SPEEDS_REDUCED_LSB +: 7] = q.spd_reduced;
    speeds_word[mdst_pkg::SPEEDS_REDUCED2_LSB +: 7] = q.spd_reduced2;
    trims_word = 32'h0000_0000;
    trims_word[mdst_pkg::TRIMS_RF_LSB +: 7] = q.trim_rf;
    trims_word[mdst_pkg::TRIMS_LF_LSB +: 7] = q.trim_lf;
    trims_word[mdst_pkg::TRIMS_RB_LSB +: 7] = q.trim_rb;
    trims_word[mdst_pkg::TRIMS_LB_LSB +: 7] = q.trim_lb;

    // speed update tick
    d.tick = 1'b0;
    if (q.tick_cnt == 15'(TICK_CYCLES - 1))
    begin
      d.tick_cnt = 15'h0000;
      d.tick = 1'b1;
    end
    else
    begin
      d.tick_cnt = 15'(q.tick_cnt + 15'h0001);
    end

    // bus handshake: a request is answered on the next cycle
    d.waitreq = 1'b1;
    if ((avs_read_in || avs_write_in) && q.waitreq)
    begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0000_0000;
      if (avs_read_in)
      begin
        unique case (avs_address_in)
          mdst_pkg::REG_STATUS:
            d.rdata = status_word;
          mdst_pkg::REG_SETUP:
            d.rdata = setup_word;
          mdst_pkg::REG_SPEEDS:
            d.rdata = speeds_word;
          mdst_pkg::REG_TRIMS:
            d.rdata = trims_word;
          default:
            d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // timed motion countdown
    if (q.motion == mdst_pkg::MDST_TIMED && q.tick)
    begin
      if (q.dur <= 24'h000001)
      begin
        d.dur = 24'h000000;
        d.motion = mdst_pkg::MDST_IDLE;
        d.left.speed = 7'h00;
        d.right.speed = 7'h00;
      end
      else
      begin
        d.dur = 24'(q.dur - 24'h000001);
      end
    end

    // configuration commands
    if (wr_go && avs_address_in == mdst_pkg::REG_COMMAND)
    begin
      unique case (code)
        mdst_pkg::CMD_MOTOR_TYPE_SETUP:
        begin
          d.mtype = qual[mdst_pkg::SETUP_TYPE_MSB:0];
          d.encoder = qual[mdst_pkg::SETUP_ENCODER_BIT];
          d.configured = 1'b1;
        end
        mdst_pkg::CMD_RIGHT_FORWARD_TRIM: d.trim_rf = pct(qual);
        mdst_pkg::CMD_LEFT_FORWARD_TRIM: d.trim_lf = pct(qual);
        mdst_pkg::CMD_RIGHT_BACKWARD_TRIM: d.trim_rb = pct(qual);
        mdst_pkg::CMD_LEFT_BACKWARD_TRIM: d.trim_lb = pct(qual);
        mdst_pkg::CMD_NORMAL_SPEED: d.spd_normal = pct(qual);
        mdst_pkg::CMD_REDUCED_SPEED: d.spd_reduced = pct(qual);
        mdst_pkg::CMD_REDUCED2_SPEED: d.spd_reduced2 = pct(qual);
        mdst_pkg::CMD_TURN_DURATION: d.turn_time = qual;
        mdst_pkg::CMD_MOVE_DURATION: d.move_time = qual;
        // zero would freeze the ramp, so it is kept as one
        mdst_pkg::CMD_ACCEL_STEP: d.accel_step = (qual == 8'h00) ? 8'h01 : qual;
        default:
        begin
        end
      endcase
    end

    // motion commands, ignored until the motor type is known
    if (wr_go && avs_address_in == mdst_pkg::REG_MOTION && q.configured)
    begin
      if (amount == 16'h0001 || q.encoder)
      begin
        base = q.spd_normal;
      end
      else if (amount != 16'h0000)
      begin
        base = q.spd_reduced;
      end
      scale = (kind == mdst_pkg::MOTION_TURN) ? q.turn_time : q.move_time;
      d.dur = 24'(amount) * 24'(scale);
      d.motion = (amount == 16'h0000) ? mdst_pkg::MDST_FREE : mdst_pkg::MDST_TIMED;
      unique case (kind)
        mdst_pkg::MOTION_FORWARD:
        begin
          d.left = '{fwd: 1'b1, speed: trimmed(base, q.trim_lf)};
          d.right = '{fwd: 1'b1, speed: trimmed(base, q.trim_rf)};
        end
        mdst_pkg::MOTION_BACKWARD:
        begin
          d.left = '{fwd: 1'b0, speed: trimmed(base, q.trim_lb)};
          d.right = '{fwd: 1'b0, speed: trimmed(base, q.trim_rb)};
        end
        mdst_pkg::MOTION_TURN:
        begin
          if (avs_writedata_in[mdst_pkg::MOTION_TURN_LEFT_BIT])
          begin
            d.left = '{fwd: 1'b0, speed: trimmed(base, q.trim_lb)};
            d.right = '{fwd: 1'b1, speed: trimmed(base, q.trim_rf)};
          end
          else
          begin
            d.left = '{fwd: 1'b1, speed: trimmed(base, q.trim_lf)};
            d.right = '{fwd: 1'b0, speed: trimmed(base, q.trim_rb)};
          end
        end
        mdst_pkg::MOTION_STOP:
        begin
          d.motion = mdst_pkg::MDST_IDLE;
          d.dur = 24'h000000;
          d.left.speed = 7'h00;
          d.right.speed = 7'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
      q.waitreq <= 1'b1;
      q.mtype <= mdst_pkg::SMALL_DIRECT_MOTOR_TYPE;
      q.spd_normal <= mdst_pkg::NORMAL_SPEED_RESET;
      q.spd_reduced <= mdst_pkg::REDUCED_SPEED_RESET;
      q.spd_reduced2 <= mdst_pkg::REDUCED2_SPEED_RESET;
      q.turn_time <= mdst_pkg::DURATION_RESET;
      q.move_time <= mdst_pkg::DURATION_RESET;
      q.accel_step <= mdst_pkg::ACCEL_STEP_RESET;
      q.motion <= mdst_pkg::MDST_IDLE;
      q.left <= '{fwd: 1'b1, speed: 7'h00};
      q.right <= '{fwd: 1'b1, speed: 7'h00};
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wheels

  mdst_wheel u_left (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(q.tick),
    .powered_in(q.configured),
    .step_in(q.accel_step),
    .cmd_in(q.left),
    .pwm_out(left_pwm_out),
    .fwd_out(left_fwd),
    .speed_out(left_speed)
  );

  mdst_wheel u_right (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(q.tick),
    .powered_in(q.configured),
    .step_in(q.accel_step),
    .cmd_in(q.right),
    .pwm_out(right_pwm_out),
    .fwd_out(right_fwd),
    .speed_out(right_speed)
  );

  assign left_fwd_out = left_fwd;
  assign right_fwd_out = right_fwd;
  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = q.waitreq;

endmodule

//--- hdl/mdst_wheel.sv
// Purpose: one wheel: speed ramp, direction change at standstill, PWM
// Assumes: tick is a one cycle pulse from the same clock
// Notes: a direction change first ramps to zero
`timescale 1ns/10ps
module mdst_wheel (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic powered_in,
  input wire logic [7:0] step_in,
  input wire mdst_pkg::mdst_wheel_cmd_t cmd_in,
  output logic pwm_out,
  output logic fwd_out,
  output logic [6:0] speed_out
);

  mdst_pkg::mdst_wheel_state_t q;
  mdst_pkg::mdst_wheel_state_t d;
  logic [7:0] goal;
  logic [7:0] gap;

  always_comb
  begin
    d = q;
    // hold target at zero until the wheel stands still in the old direction
    goal = (q.fwd != cmd_in.fwd) ? 8'h00 : {1'b0, cmd_in.speed};
    gap = 8'h00;
    if (tick_in)
    begin
      if ({1'b0, q.cur} < goal)
      begin
        gap = goal - {1'b0, q.cur};
        d.cur = (gap > step_in) ? 7'(q.cur + step_in[6:0]) : goal[6:0];
      end
      else if ({1'b0, q.cur} > goal)
      begin
        gap = {1'b0, q.cur} - goal;
        d.cur = (gap > step_in) ? 7'(q.cur - step_in[6:0]) : goal[6:0];
      end
    end
    if (q.cur == 7'h00 && q.fwd != cmd_in.fwd)
    begin
      d.fwd = cmd_in.fwd;
    end
    d.pwm_cnt = (q.pwm_cnt == mdst_pkg::PWM_LAST) ? 7'h00 : 7'(q.pwm_cnt + 7'h01);
    d.pwm = powered_in && (q.pwm_cnt < q.cur);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
      q.fwd <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign pwm_out = q.pwm;
  assign fwd_out = q.fwd;
  assign speed_out = q.cur;

endmodule

//--- pkg/mdst_pkg.sv
// Purpose: constants and types for the drive motor speed, trim and ramp controller
// Assumes: 20 MHz system clock, Avalon-MM register access
// Notes: command codes and register offsets are fixed here only
package mdst_pkg;

  // register byte offsets
  localparam logic [4:0] REG_COMMAND = 5'h00;
  localparam logic [4:0] REG_MOTION = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_SETUP = 5'h0C;
  localparam logic [4:0] REG_SPEEDS = 5'h14;
  localparam logic [4:0] REG_TRIMS = 5'h18;

  // command codes, in bits 15..8 of the command register
  localparam logic [7:0] CMD_MOTOR_TYPE_SETUP = 8'h01;
  localparam logic [7:0] CMD_RIGHT_FORWARD_TRIM = 8'h02;
  localparam logic [7:0] CMD_LEFT_FORWARD_TRIM = 8'h03;
  localparam logic [7:0] CMD_RIGHT_BACKWARD_TRIM = 8'h04;
  localparam logic [7:0] CMD_LEFT_BACKWARD_TRIM = 8'h05;
  localparam logic [7:0] CMD_NORMAL_SPEED = 8'h06;
  localparam logic [7:0] CMD_REDUCED_SPEED = 8'h07;
  localparam logic [7:0] CMD_REDUCED2_SPEED = 8'h08;
  localparam logic [7:0] CMD_TURN_DURATION = 8'h09;
  localparam logic [7:0] CMD_MOVE_DURATION = 8'h0A;
  localparam logic [7:0] CMD_ACCEL_STEP = 8'h0B;

  // setup qualifier and setup readback fields
  localparam int SETUP_TYPE_MSB = 2;
  localparam int SETUP_ENCODER_BIT = 3;
  localparam logic [2:0] SMALL_DIRECT_MOTOR_TYPE = 3'h0;
  localparam int SETUP_TURN_LSB = 4;
  localparam int SETUP_MOVE_LSB = 12;
  localparam int SETUP_ACCEL_LSB = 20;

  // status register fields
  localparam int STATUS_RIGHT_SPEED_LSB = 0;
  localparam int STATUS_LEFT_SPEED_LSB = 7;
  localparam int STATUS_RIGHT_FWD_BIT = 15;
  localparam int STATUS_LEFT_FWD_BIT = 16;
  localparam int STATUS_CONFIGURED_BIT = 17;
  localparam int STATUS_MOTION_LSB = 18;

  // speed and trim readback fields
  localparam int SPEEDS_NORMAL_LSB = 0;
  localparam int SPEEDS_REDUCED_LSB = 8;
  localparam int SPEEDS_REDUCED2_LSB = 16;
  localparam int TRIMS_RF_LSB = 0;
  localparam int TRIMS_LF_LSB = 8;
  localparam int TRIMS_RB_LSB = 16;
  localparam int TRIMS_LB_LSB = 24;

  // motion register fields
  localparam int MOTION_TURN_LEFT_BIT = 2;
  localparam int MOTION_AMOUNT_LSB = 16;
  localparam logic [1:0] MOTION_STOP = 2'h0;
  localparam logic [1:0] MOTION_FORWARD = 2'h1;
  localparam logic [1:0] MOTION_BACKWARD = 2'h2;
  localparam logic [1:0] MOTION_TURN = 2'h3;

  // percentages and reset values
  localparam logic [6:0] FULL_SPEED = 7'h64;
  localparam logic [6:0] PWM_LAST = 7'h63;
  localparam logic [6:0] NORMAL_SPEED_RESET = 7'h32;
  localparam logic [6:0] REDUCED_SPEED_RESET = 7'h1E;
  localparam logic [6:0] REDUCED2_SPEED_RESET = 7'h14;
  localparam logic [7:0] DURATION_RESET = 8'h0A;
  localparam logic [7:0] ACCEL_STEP_RESET = 8'h01;

  // speed update tick
  localparam int CLK_PERIOD_NS = 50;
  localparam int SPEED_TICK_US = 1000;
  localparam int SPEED_TICK_CYCLES = SPEED_TICK_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MDST_IDLE = 2'b00,
    MDST_TIMED = 2'b01,
    MDST_FREE = 2'b11
  } mdst_motion_t;

  typedef struct packed {
    logic fwd;
    logic [6:0] speed;
  } mdst_wheel_cmd_t;

  typedef struct packed {
    logic [6:0] pwm_cnt;
    logic [6:0] cur;
    logic fwd;
    logic pwm;
  } mdst_wheel_state_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic configured;
    logic [2:0] mtype;
    logic encoder;
    logic [6:0] trim_rf;
    logic [6:0] trim_lf;
    logic [6:0] trim_rb;
    logic [6:0] trim_lb;
    logic [6:0] spd_normal;
    logic [6:0] spd_reduced;
    logic [6:0] spd_reduced2;
    logic [7:0] turn_time;
    logic [7:0] move_time;
    logic [7:0] accel_step;
    mdst_motion_t motion;
    logic [23:0] dur;
    logic [14:0] tick_cnt;
    logic tick;
    mdst_wheel_cmd_t left;
    mdst_wheel_cmd_t right;
  } mdst_state_t;

endpackage

//--- test/mdst_checker.sv
// Purpose: port checks for mdst_top
// Assumes: bound into mdst_top
// Notes: configuration tracked from accepted setup writes
`timescale 1ns/10ps
module mdst_checker (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic left_pwm_out,
  input wire logic left_fwd_out,
  input wire logic right_pwm_out,
  input wire logic right_fwd_out
);
  logic cfg_q;
  logic mapped;
  assign mapped = avs_address_in inside {mdst_pkg::REG_COMMAND, mdst_pkg::REG_MOTION, mdst_pkg::REG_STATUS,
    mdst_pkg::REG_SETUP, mdst_pkg::REG_SPEEDS, mdst_pkg::REG_TRIMS};
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cfg_q <= 1'b0;
    else if (avs_write_in && !avs_waitrequest_out && avs_address_in == mdst_pkg::REG_COMMAND
             && avs_writedata_in[15:8] == mdst_pkg::CMD_MOTOR_TYPE_SETUP)
      cfg_q <= 1'b1;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_answer; s_req |=> s_ans; endproperty
  a_answer: assert property (p_answer) else $error("access not answered in one cycle");
  property p_cause; !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_unmapped; s_req and (avs_read_in && !mapped) |=> avs_readdata_out == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; avs_waitrequest_out && $past(avs_waitrequest_out) |-> $stable(avs_readdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved between accesses");
  property p_unpowered; !cfg_q |-> !left_pwm_out && !right_pwm_out; endproperty
  a_unpowered: assert property (p_unpowered) else $error("motor powered before setup");
  property p_fwd_idle; !cfg_q |-> left_fwd_out && right_fwd_out; endproperty
  a_fwd_idle: assert property (p_fwd_idle) else $error("direction moved before setup");
  property p_left_rev; $changed(left_fwd_out) |-> !left_pwm_out; endproperty
  a_left_rev: assert property (p_left_rev) else $error("left reversed while powered");
  property p_right_rev; $changed(right_fwd_out) |-> !right_pwm_out; endproperty
  a_right_rev: assert property (p_right_rev) else $error("right reversed while powered");
endmodule
bind mdst_top mdst_checker mdst_checker_i (.sys_clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .left_pwm_out, .left_fwd_out, .right_pwm_out,
  .right_fwd_out);

//--- test/mdst_motor_model.sv
// Purpose: two motors that integrate powered cycles into travel
// Assumes: pwm high means power, fwd high means forward
// Notes: travel is signed, in powered clock cycles
`timescale 1ns/10ps
module mdst_motor_model (
  input wire logic sys_clk_in,
  input wire logic left_pwm_in,
  input wire logic left_fwd_in,
  input wire logic right_pwm_in,
  input wire logic right_fwd_in,
  output int left_pos_out,
  output int right_pos_out
);
  initial left_pos_out = 0;
  initial right_pos_out = 0;
  always @(posedge sys_clk_in)
  begin
    if (left_pwm_in === 1'b1)
      left_pos_out <= left_pos_out + (left_fwd_in ? 1 : -1);
    if (right_pwm_in === 1'b1)
      right_pos_out <= right_pos_out + (right_fwd_in ? 1 : -1);
  end
endmodule

//--- test/tb.sv
// Purpose: self-checking bench for mdst_top
// Assumes: tick shortened to 20 cycles
// Notes: speeds observed through the status register
`timescale 1ns/10ps
module tb;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdata;
  logic wreq, lp, lf, rp, rf;
  int lpos, rpos;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc++;
  mdst_top #(.TICK_CYCLES(20)) mdst_top_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .left_pwm_out(lp), .left_fwd_out(lf),
    .right_pwm_out(rp), .right_fwd_out(rf));
  mdst_motor_model mdst_motor_model_i (.sys_clk_in(sys_clk_in), .left_pwm_in(lp), .left_fwd_in(lf),
    .right_pwm_in(rp), .right_fwd_in(rf), .left_pos_out(lpos), .right_pos_out(rpos));
  ////////////////////////////////////////////////////////////////
  task finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chk_in(input logic [31:0] v, input int lo, input int hi, input string m);
    compares++;
    if ((v >= lo && v <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %0d", $time, m, v);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk_in);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test;
    end
  endtask
  task cmd(input logic [7:0] c, input logic [7:0] v);
    bus(1'b1, mdst_pkg::REG_COMMAND, {16'h0000, c, v});
  endtask
  task mot(input logic [1:0] m, input logic [15:0] a);
    bus(1'b1, mdst_pkg::REG_MOTION, {a, 14'h0000, m});
  endtask
  task st;
    bus(1'b0, mdst_pkg::REG_STATUS, 32'h0);
  endtask
  task setup_rd;
    bus(1'b0, mdst_pkg::REG_SETUP, 32'h0);
  endtask
  task timed(input logic [1:0] m, input logic [15:0] a, input int lo, input int hi);
    int t0;
    int i;
    mot(m, a);
    t0 = cyc;
    for (i = 0; i < 200; i++)
    begin
      st;
      if (q[19:18] === 2'h0) break;
    end
    if (i == 200)
    begin
      n_mismatch++;
      $display("[FAIL] %0t move never ended", $time);
      finish_test;
    end
    chk_in(cyc - t0, lo, hi, "move length");
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    setup_rd;
    chk(q, 32'h0010A0A0, "setup reset");
    bus(1'b0, mdst_pkg::REG_SPEEDS, 32'h0);
    chk(q, 32'h00141E32, "speeds reset");
    bus(1'b1, 5'h10, 32'hFFFFFFFF);
    bus(1'b0, 5'h10, 32'h0);
    chk(q, 32'h0, "unmapped");
    mot(mdst_pkg::MOTION_FORWARD, 16'h0000);
    repeat (100) @(posedge sys_clk_in);
    st;
    chk(q, 32'h00018000, "unconfigured status");
    chk(lpos + rpos, 32'h0, "motors moved");
    $display("t_reset done");
  endtask
  task t_setup;
    cmd(mdst_pkg::CMD_MOTOR_TYPE_SETUP, {5'h00, mdst_pkg::SMALL_DIRECT_MOTOR_TYPE} | 8'h08);
    setup_rd;
    chk(q[3:0], 4'h8, "setup or");
    cmd(mdst_pkg::CMD_MOTOR_TYPE_SETUP, {5'h00, mdst_pkg::SMALL_DIRECT_MOTOR_TYPE} + 8'h08);
    setup_rd;
    chk(q[3:0], 4'h8, "setup add");
    cmd(mdst_pkg::CMD_MOTOR_TYPE_SETUP, 8'h05);
    cmd(mdst_pkg::CMD_ACCEL_STEP, 8'h03);
    setup_rd;
    chk({q[27:20], q[3:0]}, 12'h035, "step other type");
    cmd(mdst_pkg::CMD_MOTOR_TYPE_SETUP, 8'h00);
    cmd(mdst_pkg::CMD_ACCEL_STEP, 8'h01);
    cmd(mdst_pkg::CMD_REDUCED2_SPEED, 8'hC8);
    bus(1'b0, mdst_pkg::REG_SPEEDS, 32'h0);
    chk(q, 32'h00641E32, "second reduced clamped");
    st;
    chk(q[17], 1'b1, "configured");
    $display("t_setup done");
  endtask
  task t_ramp;
    logic [6:0] pl;
    logic [6:0] pr;
    int i;
    cmd(mdst_pkg::CMD_NORMAL_SPEED, 8'h64);
    cmd(mdst_pkg::CMD_RIGHT_FORWARD_TRIM, 8'h05);
    cmd(mdst_pkg::CMD_LEFT_FORWARD_TRIM, 8'h0A);
    mot(mdst_pkg::MOTION_FORWARD, 16'h0000);
    st;
    for (i = 0; i < 30; i++)
    begin
      pl = q[13:7];
      pr = q[6:0];
      st;
      chk_in(q[13:7], pl, pl + 1, "left ramp step");
      chk_in(q[6:0], pr, pr + 1, "right ramp step");
    end
    repeat (2200) @(posedge sys_clk_in);
    st;
    chk(q[13:7], 7'h5A, "left fwd trim");
    chk(q[6:0], 7'h5F, "right fwd trim");
    chk(lpos > 0 && rpos > 0, 1'b1, "forward travel");
    $display("t_ramp done");
  endtask
  task t_back;
    cmd(mdst_pkg::CMD_ACCEL_STEP, 8'h0A);
    cmd(mdst_pkg::CMD_RIGHT_BACKWARD_TRIM, 8'h14);
    bus(1'b0, mdst_pkg::REG_TRIMS, 32'h0);
    chk(q, 32'h00140A05, "trim settings");
    mot(mdst_pkg::MOTION_BACKWARD, 16'h0000);
    st;
    chk_in(q[13:7], 70, 90, "gradual slowdown");
    repeat (1000) @(posedge sys_clk_in);
    st;
    chk(q[16:0], {2'b00, 1'b0, 7'h64, 7'h50}, "backward trims");
    $display("t_back done");
  endtask
  task t_timed;
    cmd(mdst_pkg::CMD_ACCEL_STEP, 8'h64);
    cmd(mdst_pkg::CMD_REDUCED_SPEED, 8'h28);
    cmd(mdst_pkg::CMD_MOVE_DURATION, 8'h05);
    cmd(mdst_pkg::CMD_TURN_DURATION, 8'h02);
    mot(mdst_pkg::MOTION_STOP, 16'h0000);
    repeat (100) @(posedge sys_clk_in);
    mot(mdst_pkg::MOTION_FORWARD, 16'h0003);
    repeat (100) @(posedge sys_clk_in);
    st;
    chk({q[19:18], q[13:7], q[6:0]}, {2'h1, 7'h24, 7'h26}, "reduced move");
    timed(mdst_pkg::MOTION_FORWARD, 16'h0003, 270, 330);
    mot(mdst_pkg::MOTION_TURN, 16'h0003);
    repeat (80) @(posedge sys_clk_in);
    st;
    chk({q[16:15], q[13:7], q[6:0]}, {2'b10, 7'h24, 7'h20}, "turn right");
    timed(mdst_pkg::MOTION_TURN, 16'h0003, 90, 150);
    mot(mdst_pkg::MOTION_FORWARD, 16'h0001);
    repeat (50) @(posedge sys_clk_in);
    st;
    chk(q[13:7], 7'h5A, "single step speed");
    $display("t_timed done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_setup;
    t_ramp;
    t_back;
    t_timed;
    finish_test;
  end
endmodule
